// ===== design/lvdc_map.svh
/*
  Register map, field positions, reset values and bus constants of the
  LVDS output driver control block.
  Assumes it is included by its bare name into files that need the numbers.
*/
`ifndef LVDC_MAP_SVH
`define LVDC_MAP_SVH

// Register offsets
`define LVDC_OFF_CTL1 8'h27
`define LVDC_OFF_CTL2 8'h28

// First control register fields
`define LVDC_OVERRIDE_BIT 6
`define LVDC_CLK_EN_BIT 5
`define LVDC_LANE_HI 4
`define LVDC_LANE_LO 0
`define LVDC_CTL1_MASK 8'h7F
`define LVDC_CTL1_RST 8'h00

// Second control register fields
`define LVDC_RESET_BIT 6
`define LVDC_RATE_BIT 5
`define LVDC_INVERT_BIT 4
`define LVDC_RESERVED_BIT 7
`define LVDC_CTL2_MASK 8'h70
`define LVDC_CTL2_RST 8'h20

// Driver enables used while software does not govern the outputs
`define LVDC_LANES_ALL 5'h1F

// SMBus framing
`define LVDC_BIT_LAST 3'h7
`define LVDC_BIT_FIRST 3'h0
`define LVDC_DEV_ADDR 7'h2A

`endif

// ===== design/lvdc_pkg.sv
/*
  Types shared by the LVDS output driver control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lvdc_pkg;

  // SMBus slave engine states
  typedef enum logic [3:0] {
    LVDC_ST_IDLE,
    LVDC_ST_ADDR,
    LVDC_ST_ADDR_ACK,
    LVDC_ST_OFFS,
    LVDC_ST_OFFS_ACK,
    LVDC_ST_WDATA,
    LVDC_ST_WDATA_ACK,
    LVDC_ST_RDATA,
    LVDC_ST_RDATA_ACK
  } lvdc_state_t;

endpackage : lvdc_pkg

// ===== design/lvdc_smb_if.sv
/*
  Carries synchronised SMBus line events from the pin front end to the
  slave engine.
  Assumes both ends run on ref_clk.
*/
interface lvdc_smb_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport det (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport eng (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : lvdc_smb_if

// ===== design/lvdc_smb_pins.sv
/*
  SMBus pin front end: two-flop synchronisers on SCL and SDA, then edge,
  start and stop detection on the synchronised levels.
  Assumes SCL runs far slower than ref_clk (at least eight samples a bit).
*/
module lvdc_smb_pins import lvdc_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  lvdc_smb_if.det ev
);

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // Synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], smb_scl};
      sda_sync_reg <= {sda_sync_reg[0], smb_sda_in};
    end
  end

  // Previous synchronised levels for edge detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // Line events; start and stop are SDA edges while SCL is high
  assign ev.scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
  assign ev.scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
  assign ev.start = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  assign ev.stop = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
  assign ev.sda = sda_sync_reg[1];

endmodule : lvdc_smb_pins

// ===== design/lvdc_top.sv
/*
  LVDS output driver control: SMBus slave holding the two LVDS control
  registers, driver enables, forwarded clock rate, polarity and block reset.
  Assumes SMBus pins arrive asynchronously and the board resolves SDA from
  smb_sda_oe (open drain, driven low while enabled).
*/
//
// Contract
// R1 - Override bit one hands LVDS driver enables to SMBus bits; resets zero.
// R2 - Bit five of first register enables forwarded clock driver; resets zero.
// R3 - Bits four to zero enable data lane drivers four to zero; reset zero.
// R4 - Rate bit five at 28h: one full DDR clock, zero half rate; resets one.
// R5 - Polarity bit in second register inverts the forwarded clock when set.
// R6 - Bit six of second register resets the LVDS output block; bit seven reserved.
`include "lvdc_map.svh"

module lvdc_top import lvdc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `LVDC_DEV_ADDR // Arbitrary bus address
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe,
  output logic [4:0] lvds_lane_en,
  output logic forwarded_clock_en,
  output logic forwarded_lvds_clock,
  output logic forwarded_clock_rate_select,
  output logic lvds_block_reset
);

  lvdc_smb_if ev ();

  lvdc_state_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] offs_reg;
  logic [7:0] ctl1_reg;
  logic [7:0] ctl2_reg;
  logic [1:0] phase_reg;
  logic ack_phase_reg;
  logic sda_oe_reg;
  logic sda_out_reg;
  logic [4:0] lane_en_reg;
  logic clk_en_reg;
  logic fwd_clk_reg;
  logic rate_reg;
  logic blk_rst_reg;
  logic wr_fire;
  logic [7:0] wr_byte;
  logic [7:0] rd_first;
  logic chk_armed_reg;
  logic [4:0] lane_en_next;
  logic clk_en_next;
  logic run_next;

  // Register read decode, used at both read load points
  function automatic logic [7:0] lvdc_reg_read(input logic [7:0] offs, input logic [7:0] c1,
                                               input logic [7:0] c2);
    lvdc_reg_read = 8'h00;
    if (offs == `LVDC_OFF_CTL1) begin
      lvdc_reg_read = c1 & `LVDC_CTL1_MASK;
    end else if (offs == `LVDC_OFF_CTL2) begin
      lvdc_reg_read = c2 & `LVDC_CTL2_MASK; // Reserved bits read zero
    end
  endfunction : lvdc_reg_read

  lvdc_smb_pins u_pins (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .smb_scl(smb_scl),
    .smb_sda_in(smb_sda_in),
    .ev(ev.det)
  );

  // Completed write data byte
  assign wr_byte = {shift_reg[6:0], ev.sda};
  // First byte of a read, loaded when the address acknowledge ends
  assign rd_first = lvdc_reg_read(offs_reg, ctl1_reg, ctl2_reg);
  assign wr_fire = ev.scl_rise && (state_reg == LVDC_ST_WDATA) && (bit_cnt_reg == `LVDC_BIT_LAST);

  // SMBus slave engine: samples on SCL rise, changes SDA on SCL fall
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= LVDC_ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= `LVDC_BIT_FIRST;
      offs_reg <= 8'h00;
      ack_phase_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (ev.stop) begin
      state_reg <= LVDC_ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (ev.start) begin
      state_reg <= LVDC_ST_ADDR; // Start or repeated start
      bit_cnt_reg <= `LVDC_BIT_FIRST;
      sda_oe_reg <= 1'b0;
    end else if (ev.scl_rise) begin
      unique case (state_reg)
        LVDC_ST_ADDR, LVDC_ST_OFFS, LVDC_ST_WDATA: begin
          shift_reg <= wr_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `LVDC_BIT_LAST) begin
            ack_phase_reg <= 1'b0;
            if (state_reg == LVDC_ST_ADDR) begin
              state_reg <= (wr_byte[7:1] == DEV_ADDR) ? LVDC_ST_ADDR_ACK : LVDC_ST_IDLE;
            end else if (state_reg == LVDC_ST_OFFS) begin
              offs_reg <= wr_byte;
              state_reg <= LVDC_ST_OFFS_ACK;
            end else begin
              state_reg <= LVDC_ST_WDATA_ACK;
            end
          end
        end
        LVDC_ST_RDATA: begin
          shift_reg <= {shift_reg[6:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == `LVDC_BIT_LAST) begin
            state_reg <= LVDC_ST_RDATA_ACK;
          end
        end
        LVDC_ST_RDATA_ACK: begin
          if (ev.sda) begin
            state_reg <= LVDC_ST_IDLE; // Master ended the read
          end else begin
            state_reg <= LVDC_ST_RDATA;
            offs_reg <= offs_reg + 8'h01;
            bit_cnt_reg <= `LVDC_BIT_FIRST;
            shift_reg <= lvdc_reg_read(offs_reg + 8'h01, ctl1_reg, ctl2_reg);
          end
        end
        LVDC_ST_IDLE, LVDC_ST_ADDR_ACK, LVDC_ST_OFFS_ACK, LVDC_ST_WDATA_ACK: begin
        end
      endcase
    end else if (ev.scl_fall) begin
      unique case (state_reg)
        LVDC_ST_ADDR_ACK, LVDC_ST_OFFS_ACK, LVDC_ST_WDATA_ACK: begin
          if (!ack_phase_reg) begin
            ack_phase_reg <= 1'b1;
            sda_oe_reg <= 1'b1; // Drive acknowledge low
          end else begin
            bit_cnt_reg <= `LVDC_BIT_FIRST;
            if (state_reg == LVDC_ST_ADDR_ACK && shift_reg[0]) begin
              state_reg <= LVDC_ST_RDATA;
              shift_reg <= rd_first;
              sda_oe_reg <= ~rd_first[`LVDC_RESERVED_BIT]; // Pull low for a zero MSB
            end else begin
              state_reg <= (state_reg == LVDC_ST_ADDR_ACK) ? LVDC_ST_OFFS : LVDC_ST_WDATA;
              sda_oe_reg <= 1'b0;
            end
            if (state_reg == LVDC_ST_WDATA_ACK) begin
              offs_reg <= offs_reg + 8'h01; // Auto-increment for burst writes
            end
          end
        end
        LVDC_ST_RDATA: sda_oe_reg <= ~shift_reg[7];
        LVDC_ST_RDATA_ACK: sda_oe_reg <= 1'b0; // Master drives its acknowledge
        LVDC_ST_IDLE, LVDC_ST_ADDR, LVDC_ST_OFFS, LVDC_ST_WDATA: begin
        end
      endcase
    end
  end

  // Open drain: data level is always low, enable decides
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  // Control register writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl1_reg <= `LVDC_CTL1_RST; // [R1] [R2] [R3]
      ctl2_reg <= `LVDC_CTL2_RST; // [R4] [R6]
    end else if (wr_fire) begin
      if (offs_reg == `LVDC_OFF_CTL1) begin
        ctl1_reg <= wr_byte & `LVDC_CTL1_MASK;
      end
      if (offs_reg == `LVDC_OFF_CTL2) begin
        ctl2_reg <= wr_byte & `LVDC_CTL2_MASK; // Bit seven stays zero [R6]
      end
    end
  end

  // Driver enables follow the register bits only under override
  assign lane_en_next = ctl1_reg[`LVDC_OVERRIDE_BIT] ?
                        ctl1_reg[`LVDC_LANE_HI:`LVDC_LANE_LO] : `LVDC_LANES_ALL; // [R1] [R3]
  assign clk_en_next = ctl1_reg[`LVDC_OVERRIDE_BIT] ? ctl1_reg[`LVDC_CLK_EN_BIT] : 1'b1; // [R1] [R2]
  assign run_next = clk_en_next && !ctl2_reg[`LVDC_RESET_BIT];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lane_en_reg <= 5'h00;
      clk_en_reg <= 1'b0;
      blk_rst_reg <= 1'b0;
      rate_reg <= 1'b1;
    end else begin
      lane_en_reg <= lane_en_next;
      clk_en_reg <= clk_en_next;
      blk_rst_reg <= ctl2_reg[`LVDC_RESET_BIT]; // [R6]
      rate_reg <= ctl2_reg[`LVDC_RATE_BIT]; // [R4]
    end
  end

  // Forwarded clock: full rate toggles every cycle, half rate every second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 2'h0;
      fwd_clk_reg <= 1'b0;
    end else if (!run_next) begin
      phase_reg <= 2'h0; // Held while driver off or block in reset [R6]
      fwd_clk_reg <= ctl2_reg[`LVDC_INVERT_BIT]; // [R5]
    end else begin
      phase_reg <= phase_reg + 2'h1;
      fwd_clk_reg <= (ctl2_reg[`LVDC_RATE_BIT] ? phase_reg[0] : phase_reg[1])
                     ^ ctl2_reg[`LVDC_INVERT_BIT]; // [R4] [R5]
    end
  end

  assign smb_sda_out = sda_out_reg;
  assign smb_sda_oe = sda_oe_reg;
  assign lvds_lane_en = lane_en_reg;
  assign forwarded_clock_en = clk_en_reg;
  assign forwarded_lvds_clock = fwd_clk_reg;
  assign forwarded_clock_rate_select = rate_reg;
  assign lvds_block_reset = blk_rst_reg;

  // Checks start one edge after reset release, once the outputs hold live values
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_armed_reg <= 1'b0;
    end else begin
      chk_armed_reg <= 1'b1;
    end
  end

  // Checks on the documented behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n || !chk_armed_reg);

  property p_override;
    !ctl1_reg[`LVDC_OVERRIDE_BIT] [*2] |-> lvds_lane_en == `LVDC_LANES_ALL && forwarded_clock_en;
  endproperty
  a_override: assert property (p_override) else $error("drivers not released without override"); // [R1]

  property p_write_ctl1;
    wr_fire && offs_reg == `LVDC_OFF_CTL1 |=> ##1 ctl1_reg[`LVDC_OVERRIDE_BIT] |->
      lvds_lane_en == ctl1_reg[`LVDC_LANE_HI:`LVDC_LANE_LO];
  endproperty
  a_write_ctl1: assert property (p_write_ctl1) else $error("lane enables miss written value"); // [R1]

  property p_clk_en;
    ctl1_reg[`LVDC_OVERRIDE_BIT] && !ctl1_reg[`LVDC_CLK_EN_BIT] |=> !forwarded_clock_en;
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock driver enabled while bit clear"); // [R2]

  property p_lanes;
    ctl1_reg[`LVDC_OVERRIDE_BIT] |=> lvds_lane_en == $past(ctl1_reg[`LVDC_LANE_HI:`LVDC_LANE_LO]);
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane enable mismatch"); // [R3]

  property p_full_rate;
    (run_next && ctl2_reg[`LVDC_RATE_BIT] && $stable(ctl2_reg)) [*3] |-> fwd_clk_reg != $past(fwd_clk_reg);
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate clock did not toggle"); // [R4]

  property p_half_rate;
    (run_next && !ctl2_reg[`LVDC_RATE_BIT] && $stable(ctl2_reg)) [*5] |->
      fwd_clk_reg != $past(fwd_clk_reg, 2) && ($past(fwd_clk_reg) == fwd_clk_reg || $past(fwd_clk_reg) ==
      $past(fwd_clk_reg, 2));
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate clock has wrong period"); // [R4]

  property p_polarity;
    !run_next |=> forwarded_lvds_clock == $past(ctl2_reg[`LVDC_INVERT_BIT]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("idle clock level ignores polarity"); // [R5]

  property p_block_reset;
    ctl2_reg[`LVDC_RESET_BIT] |=> lvds_block_reset ##0 forwarded_lvds_clock == $past(ctl2_reg[`LVDC_INVERT_BIT]);
  endproperty
  a_block_reset: assert property (p_block_reset) else $error("block reset not applied"); // [R6]

  property p_reserved;
    ctl2_reg[`LVDC_RESERVED_BIT] == 1'b0 && ctl1_reg[`LVDC_RESERVED_BIT] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [R6]

  property p_cov_write;
    wr_fire ##1 ctl1_reg[`LVDC_OVERRIDE_BIT];
  endproperty
  c_write: cover property (p_cov_write);

  property p_cov_read;
    state_reg == LVDC_ST_RDATA_ACK ##[1:200] state_reg == LVDC_ST_IDLE;
  endproperty
  c_read: cover property (p_cov_read);

  property p_cov_half;
    run_next && !ctl2_reg[`LVDC_RATE_BIT] ##1 $rose(fwd_clk_reg);
  endproperty
  c_half: cover property (p_cov_half);

endmodule : lvdc_top

// ===== testbench/lvdc_host.sv
/* SMBus host model: drives SCL and its side of SDA, samples SDA.
   Assumes the bench resolves SDA with a pull-up. */
module lvdc_host (
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Whole reference clock periods
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tk
  // One bit: 160 ns period, data moved mid low phase
  task automatic bitx(input logic b, output logic r);
    sda_m <= b;
    tk(2);
    scl <= 1'b1;
    tk(4);
    r = sda;
    scl <= 1'b0;
    tk(2);
  endtask : bitx
  // Start, also used as repeated start
  task automatic start();
    sda_m <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_m <= 1'b0;
    tk(4);
    scl <= 1'b0;
    tk(2);
  endtask : start
  // Stop, leaves both lines released
  task automatic stop();
    sda_m <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_m <= 1'b1;
    tk(4);
  endtask : stop
  // Eight bits MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(a, ack);
  endtask : xfer
endmodule : lvdc_host

// ===== testbench/testbench.sv
/* Self-checking bench: host model writes and reads the LVDS control
   registers; a bench model predicts every output except smb_sda_oe.
   Assumes the register map header and the host model. */
`include "lvdc_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl, sda_m, sda_o, sda_oe, clk_en, fclk, rate, brst, ack;
  logic [4:0] lane_en;
  logic [7:0] exp_q [$];
  logic [7:0] ex;
  // Pull-up resolution: the slave pulls low only while enabled and driving zero
  wire sda = sda_m & ~(sda_oe & ~sda_o);
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int unsigned rng = 90496;
  logic [7:0] c1 = 8'h00, c2 = 8'h20, r1, r2, jk;
  logic [7:0] tv [8] = '{8'hFF, 8'h50, 8'h55, 8'h10, 8'h60, 8'h00, 8'h3F, 8'hB0};
  localparam logic [7:0] AW = {`LVDC_DEV_ADDR, 1'b0};
  // Clock and hang guard
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  lvdc_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  lvdc_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .smb_scl(scl), .smb_sda_in(sda),
    .smb_sda_out(sda_o), .smb_sda_oe(sda_oe), .lvds_lane_en(lane_en), .forwarded_clock_en(clk_en),
    .forwarded_lvds_clock(fclk), .forwarded_clock_rate_select(rate), .lvds_block_reset(brst));
  // Xorshift source for register values
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : rnd
  // Byte the slave must acknowledge
  task automatic sb(input logic [7:0] b);
    host.xfer(b, 1'b1, jk, ack);
    `CHK(ack, 1'b0)
  endtask : sb
  // Model of the two registers, unmapped offsets dropped
  task automatic put(input logic [7:0] o, input logic [7:0] d);
    if (o == `LVDC_OFF_CTL1) c1 = d & `LVDC_CTL1_MASK;
    if (o == `LVDC_OFF_CTL2) c2 = d & `LVDC_CTL2_MASK;
  endtask : put
  // Two-byte write burst with auto-increment
  task automatic wr(input logic [7:0] o, input logic [7:0] d1, input logic [7:0] d2);
    host.start();
    sb(AW);
    sb(o);
    sb(d1);
    sb(d2);
    host.stop();
    put(o, d1);
    put(o + 8'h01, d2);
  endtask : wr
  // Two-byte read burst after a repeated start
  task automatic rd(input logic [7:0] o);
    host.start();
    sb(AW);
    sb(o);
    host.start();
    sb(AW | 8'h01);
    host.xfer(8'hFF, 1'b0, r1, ack);
    host.xfer(8'hFF, 1'b1, r2, ack);
    host.stop();
  endtask : rd
  // Compare drivers, clock activity and read-back with the model
  task automatic check();
    logic run, p;
    int tg;
    run = (c1[6] ? c1[5] : 1'b1) & ~c2[6];
    host.tk(4);
    `CHK(lane_en, c1[6] ? c1[4:0] : 5'h1F)
    `CHK(clk_en, c1[6] ? c1[5] : 1'b1)
    `CHK(rate, c2[5])
    `CHK(brst, c2[6])
    `CHK(sda_o, 1'b0)
    tg = 0;
    p = fclk;
    repeat (16) begin
      @(posedge ref_clk);
      tg += (fclk !== p);
      p = fclk;
    end
    `CHK(tg, run ? (c2[5] ? 16 : 8) : 0)
    if (!run) `CHK(fclk, c2[4])
    exp_q.push_back(c1);
    exp_q.push_back(c2);
    rd(`LVDC_OFF_CTL1);
    ex = exp_q.pop_front();
    `CHK(r1, ex)
    ex = exp_q.pop_front();
    `CHK(r2, ex)
  endtask : check
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    host.tk(8);
    reset_n <= 1'b1;
    host.tk(4);
    check();
    $display("reset values done");
    for (int i = 0; i < 4; i++) wr(`LVDC_OFF_CTL1, tv[2*i], tv[2*i+1]);
    for (int i = 0; i < 4; i++) check();
    for (int i = 0; i < 4; i++) begin
      wr(`LVDC_OFF_CTL1, tv[2*i], tv[2*i+1]);
      check();
    end
    $display("fixed cases done");
    for (int i = 0; i < 6; i++) begin
      wr(`LVDC_OFF_CTL1, rnd(), rnd());
      check();
    end
    $display("random cases done");
    wr(8'h26, 8'hFF, 8'h7A);
    check();
    rd(8'h29);
    `CHK(r1, 8'h00)
    host.start();
    host.xfer(AW ^ 8'h02, 1'b1, jk, ack);
    host.stop();
    `CHK(ack, 1'b1)
    $display("unmapped and foreign address done");
    reset_n <= 1'b0;
    host.tk(3);
    reset_n <= 1'b1;
    c1 = 8'h00;
    c2 = 8'h20;
    host.tk(4);
    check();
    $display("mid-run reset done");
    end_of_test();
  end
endmodule : testbench
